/* rtl/jtap_map.svh */
`ifndef JTAP_MAP_SVH
`define JTAP_MAP_SVH

`define JTAP_IR_LEN       4
`define JTAP_DR_LEN       32
`define JTAP_IR_CAPTURE   4'h1
`define JTAP_IR_RESET     4'hF
`define JTAP_IR_BYPASS    4'hF
`define JTAP_IR_DATA      4'h2
`define JTAP_PUD_BIT      0
`define JTAP_TCK_NS       80

`endif

/* rtl/jtap_pkg.sv */
package jtap_pkg;

	typedef enum logic [3:0] {
		JTAP_RESET, JTAP_IDLE, JTAP_SEL_DR, JTAP_CAP_DR, JTAP_SH_DR, JTAP_EX1_DR,
		JTAP_PAU_DR, JTAP_EX2_DR, JTAP_UPD_DR, JTAP_SEL_IR, JTAP_CAP_IR, JTAP_SH_IR,
		JTAP_EX1_IR, JTAP_PAU_IR, JTAP_EX2_IR, JTAP_UPD_IR
	} jtap_state_t;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic trst_n;
	} jtap_pins_t;

	typedef struct packed {
		logic [31:0] data;
	} jtap_word_t;

endpackage

/* rtl/jtap_port.sv */
`timescale 1ns/100ps
`include "jtap_map.svh"
// What this block does
// - Test logic runs on the system clock and steps on sampled test clock edges, which shift all serial data.
// - Mode select sampled on each rising test clock edge steps the TAP state machine.
// - Data-in bit captured on each rising test clock edge in shift-IR or shift-DR into the selected path.
// - Data output driven only in shift-IR or shift-DR, otherwise released.
// - Data output changes on the falling test clock edge.
// - Pull-up disable bit set turns off mode-select and data-in pad pull-ups.
module jtap_port import jtap_pkg::*; (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire jtap_pins_t pins,
	input  wire logic [7:0] sysint_pullup_disable_reg,
	output logic            tdo_o,
	output logic            tdo_oe,
	output logic            tms_pullup_en,
	output logic            tdi_pullup_en,
	output logic            word_valid,
	input  wire logic       word_ready,
	output jtap_word_t      word_data,
	output logic [3:0]      ir_value,
	output jtap_state_t     tap_state
);

	logic [3:0]  tck_sync_reg;
	logic [1:0]  tms_sync_reg;
	logic [1:0]  tdi_sync_reg;
	logic [1:0]  trst_sync_reg;
	logic        tck_prev_reg;
	logic        tck_rise;
	logic        tck_fall;
	logic        trst_active;
	jtap_state_t state_reg;
	jtap_state_t state_next;
	logic [`JTAP_IR_LEN-1:0] ir_shift_reg;
	logic [`JTAP_IR_LEN-1:0] ir_reg;
	logic [`JTAP_DR_LEN-1:0] dr_shift_reg;
	logic        bypass_reg;
	logic        tdo_reg;
	logic        tdo_oe_reg;
	logic        ser_bit;
	logic        push_valid;
	logic        push_ready;
	jtap_word_t  buf_mem [2];
	logic        wr_ptr_reg;
	logic        rd_ptr_reg;
	logic [1:0]  count_reg;

	// Instruction decode shared by the shift path, the output mux and the push strobe.
	function automatic logic jtap_data_sel(input logic [`JTAP_IR_LEN-1:0] code);
		return code == `JTAP_IR_DATA;
	endfunction

	// Test data output is driven only while an instruction or data scan shifts.
	function automatic logic jtap_in_shift(input jtap_state_t st);
		return (st == JTAP_SH_IR) || (st == JTAP_SH_DR);
	endfunction

	// Pins come from another domain, so each passes two flops first.
	// The test reset stage resets to its active level, so the port holds in Test-Logic-Reset.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tck_sync_reg  <= 4'h0;
			tms_sync_reg  <= 2'h3;
			tdi_sync_reg  <= 2'h3;
			trst_sync_reg <= 2'h0;
		end else begin
			tck_sync_reg  <= {tck_sync_reg[2:0], pins.tck};
			tms_sync_reg  <= {tms_sync_reg[0], pins.tms};
			tdi_sync_reg  <= {tdi_sync_reg[0], pins.tdi};
			trst_sync_reg <= {trst_sync_reg[0], pins.trst_n};
		end
	end

	// The clock is delayed two more stages so mode and data are settled when its edge is seen.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tck_prev_reg <= 1'b0;
		end else begin
			tck_prev_reg <= tck_sync_reg[3];
		end
	end

	assign tck_rise    = tck_sync_reg[3] & ~tck_prev_reg;
	assign tck_fall    = ~tck_sync_reg[3] & tck_prev_reg;
	assign trst_active = ~trst_sync_reg[1];

	// All sixteen state codes are legal, so the case needs no default.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			JTAP_RESET:  state_next = tms_sync_reg[1] ? JTAP_RESET : JTAP_IDLE;
			JTAP_IDLE:   state_next = tms_sync_reg[1] ? JTAP_SEL_DR : JTAP_IDLE;
			JTAP_SEL_DR: state_next = tms_sync_reg[1] ? JTAP_SEL_IR : JTAP_CAP_DR;
			JTAP_CAP_DR: state_next = tms_sync_reg[1] ? JTAP_EX1_DR : JTAP_SH_DR;
			JTAP_SH_DR:  state_next = tms_sync_reg[1] ? JTAP_EX1_DR : JTAP_SH_DR;
			JTAP_EX1_DR: state_next = tms_sync_reg[1] ? JTAP_UPD_DR : JTAP_PAU_DR;
			JTAP_PAU_DR: state_next = tms_sync_reg[1] ? JTAP_EX2_DR : JTAP_PAU_DR;
			JTAP_EX2_DR: state_next = tms_sync_reg[1] ? JTAP_UPD_DR : JTAP_SH_DR;
			JTAP_UPD_DR: state_next = tms_sync_reg[1] ? JTAP_SEL_DR : JTAP_IDLE;
			JTAP_SEL_IR: state_next = tms_sync_reg[1] ? JTAP_RESET : JTAP_CAP_IR;
			JTAP_CAP_IR: state_next = tms_sync_reg[1] ? JTAP_EX1_IR : JTAP_SH_IR;
			JTAP_SH_IR:  state_next = tms_sync_reg[1] ? JTAP_EX1_IR : JTAP_SH_IR;
			JTAP_EX1_IR: state_next = tms_sync_reg[1] ? JTAP_UPD_IR : JTAP_PAU_IR;
			JTAP_PAU_IR: state_next = tms_sync_reg[1] ? JTAP_EX2_IR : JTAP_PAU_IR;
			JTAP_EX2_IR: state_next = tms_sync_reg[1] ? JTAP_UPD_IR : JTAP_SH_IR;
			JTAP_UPD_IR: state_next = tms_sync_reg[1] ? JTAP_SEL_DR : JTAP_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= JTAP_RESET;
		end else if (trst_active) begin
			state_reg <= JTAP_RESET;
		end else if (tck_rise) begin
			state_reg <= state_next;
		end
	end

	// Test-Logic-Reset reloads the instruction, so the port always comes up in bypass.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ir_shift_reg <= `JTAP_IR_CAPTURE;
			ir_reg       <= `JTAP_IR_RESET;
		end else if (trst_active || state_reg == JTAP_RESET) begin
			ir_reg <= `JTAP_IR_RESET;
		end else if (tck_rise) begin
			unique case (state_reg)
				JTAP_CAP_IR: ir_shift_reg <= `JTAP_IR_CAPTURE;
				JTAP_SH_IR:  ir_shift_reg <= {tdi_sync_reg[1], ir_shift_reg[`JTAP_IR_LEN-1:1]};
				JTAP_UPD_IR: ir_reg <= ir_shift_reg;
				default:     ir_shift_reg <= ir_shift_reg;
			endcase
		end
	end

	// Captured data words are the last shifted word, so a host can loop data back.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dr_shift_reg <= '0;
			bypass_reg   <= 1'b0;
		end else if (tck_rise) begin
			if (state_reg == JTAP_CAP_DR) begin
				bypass_reg <= 1'b0;
			end else if (state_reg == JTAP_SH_DR) begin
				if (jtap_data_sel(ir_reg)) begin
					dr_shift_reg <= {tdi_sync_reg[1], dr_shift_reg[`JTAP_DR_LEN-1:1]};
				end else begin
					// Any other instruction routes data through the one-bit bypass stage.
					bypass_reg <= tdi_sync_reg[1];
				end
			end
		end
	end

	// A word is offered once, on the rising edge that leaves Update-DR.
	assign push_valid = tck_rise && state_reg == JTAP_UPD_DR && jtap_data_sel(ir_reg);

	// Shift-IR reads the instruction shifter; otherwise the selected data path feeds out.
	always_comb begin
		if (state_reg == JTAP_SH_IR) begin
			ser_bit = ir_shift_reg[0];
		end else if (jtap_data_sel(ir_reg)) begin
			ser_bit = dr_shift_reg[0];
		end else begin
			ser_bit = bypass_reg;
		end
	end

	// The output moves only after a falling test clock edge is seen, four to five system clocks late, so the host
	// sees half a period less that delay of settled data before it samples on the next rise.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tdo_reg    <= 1'b0;
			tdo_oe_reg <= 1'b0;
		end else if (trst_active) begin
			tdo_oe_reg <= 1'b0;
		end else if (tck_fall) begin
			tdo_reg    <= ser_bit;
			tdo_oe_reg <= jtap_in_shift(state_reg);
		end
	end

	// The host cannot be stalled, so a word that arrives while both entries are full
	// is dropped; two entries ride out a consumer stall of one whole data scan.
	assign push_ready = (count_reg != 2'h2);
	assign word_valid = (count_reg != 2'h0);
	assign word_data  = buf_mem[rd_ptr_reg];

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			buf_mem[0] <= '0;
			buf_mem[1] <= '0;
			wr_ptr_reg <= 1'b0;
		end else if (push_valid && push_ready) begin
			buf_mem[wr_ptr_reg] <= jtap_word_t'(dr_shift_reg);
			wr_ptr_reg          <= ~wr_ptr_reg;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_ptr_reg <= 1'b0;
			count_reg  <= 2'h0;
		end else begin
			if (word_valid && word_ready) begin
				rd_ptr_reg <= ~rd_ptr_reg;
			end
			// A push and a pop in the same cycle leave the fill level unchanged.
			count_reg <= count_reg + 2'(push_valid && push_ready) - 2'(word_valid && word_ready);
		end
	end

	assign tdo_o         = tdo_reg;
	assign tdo_oe        = tdo_oe_reg;
	// Both input pads share the one test-port disable bit.
	assign tms_pullup_en = ~sysint_pullup_disable_reg[`JTAP_PUD_BIT];
	assign tdi_pullup_en = ~sysint_pullup_disable_reg[`JTAP_PUD_BIT];
	assign ir_value      = ir_reg;
	assign tap_state     = state_reg;

endmodule // jtap_port

/* testbench/jtap_port_props.sv */
`timescale 1ns/100ps
module jtap_port_props import jtap_pkg::*; (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire jtap_pins_t  pins,
	input wire logic [7:0]  sysint_pullup_disable_reg,
	input wire logic        tdo_o,
	input wire logic        tdo_oe,
	input wire logic        tms_pullup_en,
	input wire logic        tdi_pullup_en,
	input wire logic        word_valid,
	input wire logic        word_ready,
	input wire jtap_word_t  word_data,
	input wire logic [3:0]  ir_value,
	input wire jtap_state_t tap_state
);
	wire pud = sysint_pullup_disable_reg[0];
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_tms_pullup: assert property (tms_pullup_en != pud) else $error("tms pull-up");
	a_tdi_pullup: assert property (tdi_pullup_en != pud) else $error("tdi pull-up");
	a_oe_start: assert property ($rose(tdo_oe) |-> tap_state inside {JTAP_SH_DR, JTAP_SH_IR})
		else $error("tdo enabled outside shift");
	a_oe_idle: assert property (tap_state == JTAP_IDLE [*8] |-> !tdo_oe) else $error("oe idle");
	a_trst_force: assert property (!pins.trst_n [*4] |-> tap_state == JTAP_RESET && !tdo_oe)
		else $error("test reset not forced");
	a_tdo_fall: assert property ($changed(tdo_o) |-> !$past(pins.tck, 2))
		else $error("tdo moved off falling edge");
	a_state_rise: assert property ($changed(tap_state) && pins.trst_n && $past(pins.trst_n, 4)
		|-> $past(pins.tck, 2)) else $error("state moved off rising edge");
	a_word_hold: assert property (word_valid && !word_ready |=> word_valid && $stable(word_data))
		else $error("word lost");
endmodule // jtap_port_props

/* testbench/jtap_host.sv */
`timescale 1ns/100ps
module jtap_host import jtap_pkg::*; (
	input  wire logic clk,
	input  wire logic tdo_o,
	input  wire logic tdo_oe,
	output jtap_pins_t pins
);
	// The output pad has a pull-up, so a released line reads high.
	wire tdo_line = tdo_oe ? tdo_o : 1'b1;
	initial pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};
	task automatic set_trst(input logic v);
		pins.trst_n = v;
	endtask
	task automatic step(input logic m, input logic d, output logic q);
		// Entered on a falling system clock edge; five clocks low and five high make 80 ns.
		pins.tms = m;
		pins.tdi = d;
		repeat (5) @(negedge clk);
		pins.tck = 1'b1;
		q = tdo_line;
		repeat (5) @(negedge clk);
		pins.tck = 1'b0;
	endtask
	task automatic walk(input logic [4:0] s, input int n);
		logic b;
		for (int i = 0; i < n; i++) step(s[i], 1'b1, b);
	endtask
	task automatic shift(input int n, input logic [31:0] d, output logic [31:0] q);
		logic b;
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, d[i], b);
			q[i] = b;
		end
		step(1'b1, ~d[n - 1], b);
		step(1'b0, ~d[n - 1], b);
	endtask
	task automatic load_ir(input logic [3:0] c, output logic [3:0] r);
		logic [31:0] w;
		walk(5'b00110, 5);
		shift(4, {28'h0000000, c}, w);
		r = w[3:0];
	endtask
	task automatic load_dr(input logic [31:0] d, output logic [31:0] q);
		walk(5'b00010, 4);
		shift(32, d, q);
	endtask
endmodule // jtap_host

/* testbench/jtap_port_tb.sv */
`timescale 1ns/100ps
module jtap_port_tb import jtap_pkg::*;;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        word_ready = 1'b0;
	logic [7:0]  sysint_pullup_disable_reg = 8'h00;
	logic        tdo_o, tdo_oe, tms_pullup_en, tdi_pullup_en, word_valid;
	jtap_pins_t  pins;
	jtap_word_t  word_data;
	logic [3:0]  ir_value, q;
	jtap_state_t tap_state;
	int          n_errors = 0;
	int          tests_run = 0;
	int          cyc = 0;
	always #4 clk = ~clk;
	jtap_host jtap_host_inst (.clk, .tdo_o, .tdo_oe, .pins);
	jtap_port jtap_port_inst (.clk, .sys_rst, .pins, .sysint_pullup_disable_reg, .tdo_o, .tdo_oe,
		.tms_pullup_en, .tdi_pullup_en, .word_valid, .word_ready, .word_data, .ir_value, .tap_state);
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic t_basic;
		chk("state", JTAP_RESET, tap_state);
		chk("oe", 1'b0, tdo_oe);
		sysint_pullup_disable_reg = 8'h01;
		@(negedge clk);
		chk("tms_pu", 1'b0, tms_pullup_en);
		chk("tdi_pu", 1'b0, tdi_pullup_en);
		sysint_pullup_disable_reg = 8'hFE;
		@(negedge clk);
		chk("tms_pu", 1'b1, tms_pullup_en);
		chk("tdi_pu", 1'b1, tdi_pullup_en);
		jtap_host_inst.load_ir(4'h2, q);
		chk("ir_capture", 4'h1, q);
		chk("ir", 4'h2, ir_value);
		chk("state", JTAP_IDLE, tap_state);
		chk("oe", 1'b0, tdo_oe);
		$display("basic done");
	endtask
	task automatic t_stream;
		logic [31:0] w;
		jtap_host_inst.load_dr(32'hA5C3_0F01, w);
		chk("dr_out0", 32'h0000_0000, w);
		jtap_host_inst.load_dr(32'h1234_8765, w);
		chk("dr_out1", 32'hA5C3_0F01, w);
		jtap_host_inst.load_dr(32'hDEAD_BEEF, w);
		chk("dr_out2", 32'h1234_8765, w);
		chk("valid", 1'b1, word_valid);
		chk("head", 32'hA5C3_0F01, word_data);
		word_ready = 1'b1;
		@(negedge clk);
		chk("second", 32'h1234_8765, word_data);
		@(negedge clk);
		word_ready = 1'b0;
		chk("empty", 1'b0, word_valid);
		$display("stream done");
	endtask
	task automatic t_trst;
		jtap_host_inst.walk(5'b00001, 3);
		repeat (6) @(negedge clk);
		chk("oe_shift", 1'b1, tdo_oe);
		jtap_host_inst.set_trst(1'b0);
		repeat (4) @(negedge clk);
		chk("state", JTAP_RESET, tap_state);
		chk("oe", 1'b0, tdo_oe);
		chk("ir", 4'hF, ir_value);
		jtap_host_inst.set_trst(1'b1);
		repeat (3) @(negedge clk);
		$display("test reset done");
	endtask
	task automatic t_bypass;
		logic [31:0] w;
		jtap_host_inst.load_ir(4'hF, q);
		chk("ir_capture", 4'h1, q);
		chk("ir", 4'hF, ir_value);
		jtap_host_inst.walk(5'b00010, 4);
		jtap_host_inst.shift(8, 32'h0000_00B4, w);
		chk("bypass", 8'h68, w[7:0]);
		chk("no_push", 1'b0, word_valid);
		chk("state", JTAP_IDLE, tap_state);
		chk("oe", 1'b0, tdo_oe);
		$display("bypass done");
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			tally_and_finish;
		end
	end
	initial begin
		repeat (6) @(negedge clk);
		sys_rst = 1'b0;
		repeat (3) @(negedge clk);
		t_basic;
		t_stream;
		t_trst;
		t_bypass;
		tally_and_finish;
	end
endmodule // jtap_port_tb
bind jtap_port jtap_port_props jtap_port_props_inst (.clk, .sys_rst, .pins, .sysint_pullup_disable_reg,
	.tdo_o, .tdo_oe, .tms_pullup_en, .tdi_pullup_en, .word_valid, .word_ready, .word_data,
	.ir_value, .tap_state);
